// *** core/psp_host.sv ***
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module psp_host (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   psp_link_if.host         link,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq
);
   import psp_pkg::*;

   typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_LE} psp_state_type;
   psp_state_type state_reg;
   logic [31:0] tx_reg, sh_reg;
   logic [5:0]  bit_reg;
   logic [3:0]  div_reg;
   logic        go_reg, sclk_reg, le_reg;
   logic [1:0]  irq_reg, mask_reg;
   logic [1:0]  lock_sync_reg, tsel_sync_reg;
   logic        lock_prev_reg;
   logic        wr_pend_reg;
   logic [7:0]  addr_reg;
   logic        done_ev, lost_ev, wr_now;

   // One-cycle answer: always ready, OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
      end else begin
         wr_pend_reg <= hsel && hready && htrans[1] && hwrite;
         if (hsel && hready && htrans[1]) begin
            addr_reg <= haddr;
         end
      end
   end
   assign wr_now = wr_pend_reg;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_reg   <= WORD_RESET;
         mask_reg <= 2'h0;
      end else if (wr_now) begin
         if (addr_reg == OFS_TXDATA) tx_reg <= hwdata;
         if (addr_reg == OFS_MASK) mask_reg <= hwdata[1:0];
      end
   end

   // Read data taken at the address phase; a read right behind a write sees the old value
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         case (haddr)
            OFS_TXDATA: hrdata <= tx_reg;
            OFS_STATUS: hrdata <= {31'h0, state_reg != ST_IDLE || go_reg};
            OFS_IRQ:    hrdata <= {30'h0, irq_reg};
            OFS_MASK:   hrdata <= {30'h0, mask_reg};
            OFS_DEVST:  hrdata <= {30'h0, tsel_sync_reg[1], lock_sync_reg[1]};
            default:    hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Sends only when idle; writes to CTRL while busy are ignored
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         go_reg <= 1'b0;
      end else if (wr_now && addr_reg == OFS_CTRL && hwdata[0] && state_reg == ST_IDLE) begin
         go_reg <= 1'b1;
      end else if (state_reg != ST_IDLE) begin
         go_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         sh_reg    <= WORD_RESET;
         bit_reg   <= 6'h0;
         div_reg   <= 4'h0;
         sclk_reg  <= 1'b0;
         le_reg    <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               le_reg <= 1'b0;
               if (go_reg) begin
                  sh_reg    <= tx_reg;
                  bit_reg   <= 6'h0;
                  div_reg   <= 4'h0;
                  state_reg <= ST_LOW;
               end
            end
            ST_LOW: begin
               div_reg <= div_reg + 4'h1;
               if (div_reg == 4'(LINK_HALF_CYC - 1)) begin
                  div_reg   <= 4'h0;
                  sclk_reg  <= 1'b1;
                  state_reg <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               div_reg <= div_reg + 4'h1;
               if (div_reg == 4'(LINK_HALF_CYC - 1)) begin
                  div_reg  <= 4'h0;
                  sclk_reg <= 1'b0;
                  sh_reg   <= {sh_reg[30:0], 1'b0};
                  bit_reg  <= bit_reg + 6'h1;
                  state_reg <= (bit_reg == 6'h1F) ? ST_LE : ST_LOW;
               end
            end
            ST_LE: begin
               div_reg <= div_reg + 4'h1;
               if (div_reg == 4'(LINK_HALF_CYC - 1)) begin
                  le_reg    <= 1'b1;
                  div_reg   <= 4'h0;
                  state_reg <= ST_IDLE;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   // software sequences words and value ranges
   assign link.serial_clk   = sclk_reg;
   assign link.serial_data  = sh_reg[31];
   assign link.latch_strobe = le_reg;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lock_sync_reg <= 2'h0;
         tsel_sync_reg <= 2'h0;
         lock_prev_reg <= 1'b0;
      end else begin
         lock_sync_reg <= {lock_sync_reg[0], link.lock_indicator_pin};
         tsel_sync_reg <= {tsel_sync_reg[0], link.test_select_output};
         lock_prev_reg <= lock_sync_reg[1];
      end
   end
   assign done_ev = state_reg == ST_LE && div_reg == 4'(LINK_HALF_CYC - 1);
   assign lost_ev = lock_prev_reg && !lock_sync_reg[1];

   // Set wins over write-one-to-clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_reg <= 2'h0;
      end else begin
         irq_reg <= (irq_reg & ~((wr_now && addr_reg == OFS_IRQ) ? hwdata[1:0] : 2'h0))
                    | {lost_ev, done_ev};
      end
   end
   assign irq = |(irq_reg & mask_reg);
endmodule : psp_host
`default_nettype wire

// *** core/psp_pkg.sv ***
package psp_pkg;
   localparam int WORD_W          = 32;
   localparam int NUM_LATCH       = 6;
   localparam int CODE_LSB        = 0;
   localparam int CODE_W          = 3;
   localparam int FRACTION_NUMERATOR_LSB        = 3;
   localparam int INT_LSB         = 15;
   localparam int MOD_LSB         = 3;
   localparam int PHASE_LSB       = 15;
   localparam int PRESC_BIT       = 27;
   localparam int CNT_RESET_BIT   = 3;
   localparam int PWR_DOWN_BIT    = 5;
   localparam int LDF_BIT         = 8;
   localparam int CP_LSB          = 9;
   localparam int DBB_EN_BIT      = 13;
   localparam int RCNT_LSB        = 14;
   localparam int RCNT_W          = 10;
   localparam int HALVE_BIT       = 24;
   localparam int DOUBLE_BIT      = 25;
   localparam int TSEL_LSB        = 26;
   localparam int POWER_LSB       = 3;
   localparam int OUT_EN_BIT      = 5;
   localparam int MUTE_UNTIL_LOCK_BIT_BIT        = 10;
   localparam int DIVSEL_LSB      = 20;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;
   localparam int LINK_HALF_CYC   = 4;
   // Host register offsets on the AHB-Lite side
   localparam logic [7:0] OFS_TXDATA = 8'h00;
   localparam logic [7:0] OFS_CTRL   = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_IRQ    = 8'h0C;
   localparam logic [7:0] OFS_MASK   = 8'h10;
   localparam logic [7:0] OFS_DEVST  = 8'h14;
   typedef enum logic [2:0] {
      TSEL_TRISTATE, TSEL_DVDD, TSEL_DGND, TSEL_RDIV,
      TSEL_NDIV, TSEL_ALOCK, TSEL_DLOCK, TSEL_RSVD
   } psp_tsel_type;
endpackage : psp_pkg

// *** core/psp_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface psp_link_if;
   logic serial_clk;
   logic serial_data;
   logic latch_strobe;
   logic lock_indicator_pin;
   logic test_select_output;
   modport device (input serial_clk, input serial_data, input latch_strobe,
                   output lock_indicator_pin, output test_select_output);
   modport host   (output serial_clk, output serial_data, output latch_strobe,
                   input lock_indicator_pin, input test_select_output);
endinterface : psp_link_if
`default_nettype wire

// *** core/psp_device.sv ***
`timescale 1ns/10ps
`default_nettype none
module psp_device (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   psp_link_if.device      link,
   input  wire logic       loop_locked,
   input  wire logic       ref_div_tick,
   input  wire logic       n_div_tick,
   output logic [15:0]     int_value,
   output logic [11:0]     fraction_numerator,
   output logic [11:0]     fraction_modulus,
   output logic [11:0]     phase_value,
   output logic            prescaler_89,
   output logic [9:0]      ref_count,
   output logic            ref_doubler,
   output logic            ref_halve,
   output logic [2:0]      cp_current,
   output logic            integer_mode,
   output logic            power_down,
   output logic            ref_isolate,
   output logic            counter_reset,
   output logic [2:0]      out_divider_sel,
   output logic [1:0]      out_power_level,
   output logic            out_stage_supply_on,
   output logic [11:0]     clock_divider,
   output logic [31:0]     word3_raw,
   output logic [31:0]     word5_raw
);
   import psp_pkg::*;

   logic [2:0]  sclk_sync_reg, sdat_sync_reg, le_sync_reg;
   logic [31:0] shift_reg;
   logic [31:0] word_reg [NUM_LATCH];
   logic [31:0] r1_buf_reg;
   logic [31:0] r2_buf_reg;
   logic [2:0]  div_buf_reg;
   logic        sclk_rise, le_rise;
   logic [2:0]  code;
   logic [1:0]  lock_in_sync_reg, rtick_sync_reg, ntick_sync_reg;

   // Two flops before any logic, third stage for edge finding
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_sync_reg <= 3'h0;
         sdat_sync_reg <= 3'h0;
         le_sync_reg   <= 3'h0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], link.serial_clk};
         sdat_sync_reg <= {sdat_sync_reg[1:0], link.serial_data};
         le_sync_reg   <= {le_sync_reg[1:0], link.latch_strobe};
      end
   end
   // Lock and divider ticks come from the loop side, not from clk_sys
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lock_in_sync_reg <= 2'h0;
         rtick_sync_reg   <= 2'h0;
         ntick_sync_reg   <= 2'h0;
      end else begin
         lock_in_sync_reg <= {lock_in_sync_reg[0], loop_locked};
         rtick_sync_reg   <= {rtick_sync_reg[0], ref_div_tick};
         ntick_sync_reg   <= {ntick_sync_reg[0], n_div_tick};
      end
   end
   assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
   assign le_rise   = le_sync_reg[1] & ~le_sync_reg[2];
   assign code      = shift_reg[CODE_LSB +: CODE_W];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         shift_reg <= WORD_RESET;
      end else if (sclk_rise) begin
         shift_reg <= {shift_reg[30:0], sdat_sync_reg[1]};
      end
   end

   // Only legal codes land in a latch; six and seven fall through
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_LATCH; i++) begin
            word_reg[i] <= WORD_RESET;
         end
      end else if (le_rise && code < 3'(NUM_LATCH)) begin
         word_reg[code] <= shift_reg;
      end
   end

   // Buffered copies move only when latch zero is written
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         r1_buf_reg  <= WORD_RESET;
         r2_buf_reg  <= WORD_RESET;
         div_buf_reg <= 3'h0;
      end else if (le_rise && code == 3'h0) begin
         r1_buf_reg <= word_reg[1];
         r2_buf_reg <= word_reg[2];
         if (word_reg[2][DBB_EN_BIT]) begin
            div_buf_reg <= word_reg[4][DIVSEL_LSB +: 3];
         end
      end
   end

   always_comb begin
      int_value          = word_reg[0][INT_LSB +: 16];
      fraction_numerator = word_reg[0][FRACTION_NUMERATOR_LSB +: 12];
      fraction_modulus   = r1_buf_reg[MOD_LSB +: 12];
      phase_value        = r1_buf_reg[PHASE_LSB +: 12];
      prescaler_89       = word_reg[1][PRESC_BIT];
      ref_count          = r2_buf_reg[RCNT_LSB +: RCNT_W];
      ref_doubler        = r2_buf_reg[DOUBLE_BIT];
      ref_halve          = r2_buf_reg[HALVE_BIT];
      cp_current         = r2_buf_reg[CP_LSB +: 3];
      integer_mode       = word_reg[2][LDF_BIT] && fraction_numerator == 12'h000;
      power_down         = word_reg[2][PWR_DOWN_BIT];
      ref_isolate        = power_down;
      counter_reset      = word_reg[2][CNT_RESET_BIT];
      out_divider_sel    = word_reg[2][DBB_EN_BIT] ? div_buf_reg
                                                   : word_reg[4][DIVSEL_LSB +: 3];
      out_power_level    = word_reg[4][POWER_LSB +: 2];
      out_stage_supply_on = word_reg[4][OUT_EN_BIT] && !power_down &&
                            (!word_reg[4][MUTE_UNTIL_LOCK_BIT_BIT] || lock_in_sync_reg[1]);
      clock_divider      = word_reg[3][14:3];
      word3_raw          = word_reg[3];
      word5_raw          = word_reg[5];
   end

   logic lock_reg, tout_reg;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lock_reg <= 1'b0;
         tout_reg <= 1'b0;
      end else begin
         lock_reg <= lock_in_sync_reg[1];
         case (psp_tsel_type'(word_reg[2][TSEL_LSB +: 3]))
            TSEL_DVDD:  tout_reg <= 1'b1;
            TSEL_RDIV:  tout_reg <= rtick_sync_reg[1];
            TSEL_NDIV:  tout_reg <= ntick_sync_reg[1];
            TSEL_ALOCK: tout_reg <= lock_in_sync_reg[1];
            TSEL_DLOCK: tout_reg <= lock_in_sync_reg[1];
            default:    tout_reg <= 1'b0;
         endcase
      end
   end
   assign link.lock_indicator_pin = lock_reg;
   assign link.test_select_output = tout_reg;
endmodule : psp_device
`default_nettype wire

// *** verif/psp_link_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module psp_link_props (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic serial_clk,
   input wire logic serial_data,
   input wire logic latch_strobe,
   input wire logic lock_indicator_pin,
   input wire logic test_select_output,
   input wire logic loop_locked
);
   logic       sclk_q;
   logic [5:0] rise_cnt;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // Link clock rises since the last strobe; a lost or extra bit shows here
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sclk_q   <= 1'b0;
         rise_cnt <= 6'h00;
      end else begin
         sclk_q <= serial_clk;
         if (latch_strobe)
            rise_cnt <= 6'h00;
         else if (serial_clk && !sclk_q)
            rise_cnt <= rise_cnt + 6'h01;
      end
   end
   property p_word_bits;
      $rose(latch_strobe) |-> rise_cnt == 6'h20;
   endproperty
   property p_count_cap;
      rise_cnt <= 6'h20;
   endproperty
   property p_high_phase;
      $rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk;
   endproperty
   property p_low_phase;
      $fell(serial_clk) |-> !serial_clk [*4];
   endproperty
   property p_data_low;
      $changed(serial_data) |-> !serial_clk;
   endproperty
   property p_strobe_pulse;
      $rose(latch_strobe) |=> !latch_strobe;
   endproperty
   property p_strobe_idle;
      latch_strobe |-> !serial_clk && !$past(serial_clk, 3);
   endproperty
   property p_lock_pin;
      lock_indicator_pin == $past(loop_locked, 3);
   endproperty
   a_word_bits: assert property (p_word_bits) else $error("strobe not after 32 bits");
   a_count_cap: assert property (p_count_cap) else $error("over 32 bits in a word");
   a_high_phase: assert property (p_high_phase) else $error("link clock high phase");
   a_low_phase: assert property (p_low_phase) else $error("link clock low phase");
   a_data_low: assert property (p_data_low) else $error("data moved while clock high");
   a_strobe_pulse: assert property (p_strobe_pulse) else $error("strobe too long");
   a_strobe_idle: assert property (p_strobe_idle) else $error("strobe during bits");
   a_lock_pin: assert property (p_lock_pin) else $error("lock pin wrong");
   c_strobe: cover property ($rose(latch_strobe));
   c_lock: cover property ($rose(lock_indicator_pin));
   c_tsel: cover property ($rose(test_select_output));
endmodule : psp_link_props
`default_nettype wire

// *** verif/tb_pll_serial_program_interface.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_pll_serial_program_interface;
   import psp_pkg::*;
   logic        clk_sys = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0, hrdata, raw3, raw5, r, w0, w1, w2, w4, wx;
   logic [31:0] pm = 0, prc = 0, e3 = 0, e5 = 0;
   logic        hreadyout, hresp, irq, dbl, hlv, imode, pdn, iso, supply;
   logic        loop_locked = 1'b0, rtick = 1'b0, ntick = 1'b0, mask_on = 1'b0;
   logic [15:0] int_value;
   logic [11:0] fraction_numerator_num, fraction_numerator_mod, phase;
   logic [9:0]  ref_count;
   logic [2:0]  cp, divsel, pdv = 3'h0;
   logic [1:0]  pwr;
   int          seed = 99, n_mismatch = 0, check_count = 0, k;
   psp_link_if u_link ();
   psp_device u_psp_device (.clk_sys(clk_sys), .rst(rst), .link(u_link),
      .loop_locked(loop_locked), .ref_div_tick(rtick), .n_div_tick(ntick),
      .int_value(int_value), .fraction_numerator(fraction_numerator_num), .fraction_modulus(fraction_numerator_mod),
      .phase_value(phase), .prescaler_89(), .ref_count(ref_count), .ref_doubler(dbl),
      .ref_halve(hlv), .cp_current(cp), .integer_mode(imode), .power_down(pdn),
      .ref_isolate(iso), .counter_reset(), .out_divider_sel(divsel), .out_power_level(pwr),
      .out_stage_supply_on(supply), .clock_divider(), .word3_raw(raw3), .word5_raw(raw5));
   psp_host u_psp_host (.clk_sys(clk_sys), .rst(rst), .link(u_link), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
   psp_link_props u_psp_link_props (.clk_sys(clk_sys), .rst(rst),
      .serial_clk(u_link.serial_clk), .serial_data(u_link.serial_data),
      .latch_strobe(u_link.latch_strobe), .lock_indicator_pin(u_link.lock_indicator_pin),
      .test_select_output(u_link.test_select_output), .loop_locked(loop_locked));
   always #50 clk_sys = ~clk_sys;
   // Divider ticks kept moving so the test output paths see real traffic
   always @(posedge clk_sys) begin
      rtick <= 1'($random(seed));
      ntick <= ~ntick;
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_of_test
   // Values are taken before this edge's updates land, so no race with the slave
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      haddr  <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 50);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk_sys); while (hreadyout !== 1'b1 && ++n < 50);
      r = hrdata;
      if (n >= 50) begin
         n_mismatch++;
         end_of_test();
      end
   endtask : ahb
   task automatic send(input logic [31:0] w);
      int n;
      ahb(1'b1, OFS_TXDATA, w);
      ahb(1'b1, OFS_CTRL, 32'h1);
      n = 0;
      r = 0;
      while (r[0] !== 1'b1) begin
         ahb(1'b0, OFS_IRQ, 32'h0);
         if (++n > 400) begin
            n_mismatch++;
            end_of_test();
         end
      end
      repeat (2) @(posedge clk_sys);
      chk("irq", irq, mask_on);
      ahb(1'b1, OFS_IRQ, 32'h1);
      repeat (8) @(posedge clk_sys);
      chk("irq_clr", irq, 0);
   endtask : send
   initial begin
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      for (k = 4; k <= 8'h18; k += 4) begin
         ahb(1'b0, 8'(k), 32'h0);
         chk("reg_reset", r, 0);
      end
      for (k = 0; k < 3; k++) begin
         w1 = ($random(seed) & 32'h07FF_FFF8) | 32'h11;
         w2 = ($random(seed) & 32'h03FF_CF00) | 32'h4002 | (32'(k) << TSEL_LSB) |
              (32'(k == 2) << DBB_EN_BIT) | (32'(k == 1) << PWR_DOWN_BIT);
         w0 = ($random(seed) & 32'h3FFF_8000) | (32'h17 << INT_LSB);
         send(w1);
         chk("mod_hold", fraction_numerator_mod, pm[MOD_LSB +: 12]);
         send(w2);
         chk("rc_hold", ref_count, prc[RCNT_LSB +: 10]);
         chk("pdn", pdn, w2[PWR_DOWN_BIT]);
         chk("iso", iso, w2[PWR_DOWN_BIT]);
         chk("tsel", u_link.test_select_output, k == 1);
         send(w0);
         chk("int", int_value, w0[INT_LSB +: 16]);
         chk("mod", fraction_numerator_mod, w1[MOD_LSB +: 12]);
         chk("phase", phase, w1[PHASE_LSB +: 12]);
         chk("rc", ref_count, w2[RCNT_LSB +: 10]);
         chk("dbl_hlv", {dbl, hlv}, w2[HALVE_BIT +: 2]);
         chk("cp", cp, w2[CP_LSB +: 3]);
         chk("imode", imode, w2[LDF_BIT]);
         pm  = w1;
         prc = w2;
      end
      send(w0 | 32'h8);
      chk("imode_fraction_numerator", imode, 0);
      chk("fraction_numerator", fraction_numerator_num, 1);
      w2 = (w2 & ~(32'h7 << TSEL_LSB)) | (32'(TSEL_ALOCK) << TSEL_LSB);
      send(w2);
      for (k = 0; k < 4; k++) begin
         w4 = ($random(seed) & 32'h0070_0000) | 32'h24 | (32'(k) << POWER_LSB) |
              (32'(k % 2) << MUTE_UNTIL_LOCK_BIT_BIT);
         send(w4);
         chk("pwr", pwr, k);
         chk("div_hold", divsel, pdv);
         chk("mute", supply, k % 2 == 0);
         @(posedge clk_sys) loop_locked <= 1'b1;
         repeat (4) @(posedge clk_sys);
         chk("supply_lock", supply, 1);
         chk("lock_hi", u_link.lock_indicator_pin, 1);
         chk("tsel_lock_hi", u_link.test_select_output, 1);
         @(posedge clk_sys) loop_locked <= 1'b0;
         repeat (4) @(posedge clk_sys);
         chk("lock_lo", u_link.lock_indicator_pin, 0);
         chk("tsel_lock_lo", u_link.test_select_output, 0);
         send(w0);
         pdv = w4[DIVSEL_LSB +: 3];
         chk("div", divsel, pdv);
      end
      send(w2 & ~(32'h1 << DBB_EN_BIT));
      w4 = w4 ^ 32'h0070_0000;
      send(w4);
      chk("div_direct", divsel, w4[DIVSEL_LSB +: 3]);
      ahb(1'b1, OFS_MASK, 32'h1);
      mask_on = 1'b1;
      for (k = 3; k < 8; k++) begin
         if (k != 4) begin
            wx = ($random(seed) & 32'hFFFF_FFF8) | 32'(k);
            send(wx);
            e3 = (k == 3) ? wx : e3;
            e5 = (k == 5) ? wx : e5;
            chk("raw3", raw3, e3);
            chk("raw5", raw5, e5);
            chk("int_keep", int_value, w0[INT_LSB +: 16]);
            chk("pwr_keep", pwr, 3);
         end
      end
      end_of_test();
   end
endmodule : tb_pll_serial_program_interface
`default_nettype wire
